// ==== logic/lid_pkg.sv ====
package lid_pkg;

  // Widths of the host bus and the display addresses
  localparam int DATA_W = 8;
  localparam int COL_W = 7;
  localparam int PAGE_W = 2;
  localparam int LINE_W = 5;
  localparam int RAM_ADDR_W = PAGE_W + COL_W;

  // Column counter stops here; the last segment column is one below it
  localparam logic [COL_W-1:0] COL_LIMIT = 7'h50;
  localparam logic [COL_W-1:0] SEG_LAST = 7'h4F;

  // Reset values after the hardware reset pin
  localparam logic [COL_W-1:0] COL_RST = 7'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 2'h0;
  localparam logic [LINE_W-1:0] LINE_RST = 5'h00;
  localparam logic ADC_RST = 1'b0;
  localparam logic STATIC_RST = 1'b0;
  localparam logic DUTY_RST = 1'b0;
  localparam logic DISP_ON_RST = 1'b0;

  // Page loaded by the soft reset command
  localparam logic [PAGE_W-1:0] PAGE_SOFT = 2'h3;

  // Command patterns and the masks that select their fixed bits
  localparam logic [DATA_W-1:0] MASK_BIT0 = 8'hFE;
  localparam logic [DATA_W-1:0] CMD_ADC = 8'hA0;
  localparam logic [DATA_W-1:0] CMD_STATIC = 8'hA4;
  localparam logic [DATA_W-1:0] CMD_DUTY = 8'hA8;
  localparam logic [DATA_W-1:0] CMD_DISP = 8'hAE;
  localparam logic [DATA_W-1:0] MASK_FULL = 8'hFF;
  localparam logic [DATA_W-1:0] CMD_RMW = 8'hE0;
  localparam logic [DATA_W-1:0] CMD_END = 8'hEE;
  localparam logic [DATA_W-1:0] CMD_RESET = 8'hE2;
  localparam logic [DATA_W-1:0] MASK_PAGE = 8'hFC;
  localparam logic [DATA_W-1:0] CMD_PAGE = 8'hB8;
  localparam logic [DATA_W-1:0] MASK_LINE = 8'hE0;
  localparam logic [DATA_W-1:0] CMD_LINE = 8'hC0;
  localparam logic [DATA_W-1:0] MASK_COL = 8'h80;
  localparam logic [DATA_W-1:0] CMD_COL = 8'h00;

  // Data forced onto every dot: all on in static drive, all off in power save and reset
  localparam logic [DATA_W-1:0] DOTS_ALL_ON = 8'hFF;
  localparam logic [DATA_W-1:0] DOTS_OFF = 8'h00;

  // Compare a command byte against a pattern under a mask
  function automatic logic lid_cmd_match(input logic [DATA_W-1:0] b, input logic [DATA_W-1:0] pat,
                                         input logic [DATA_W-1:0] mask);
    return (b & mask) == pat;
  endfunction : lid_cmd_match

endpackage : lid_pkg

// ==== logic/lid_ram.sv ====
`timescale 1ns/10ps
module lid_ram import lid_pkg::*; #(
  parameter int WIDTH = DATA_W,
  parameter int ADDR_W = RAM_ADDR_W,
  parameter int WORDS = 512
) (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o,
  input wire logic [ADDR_W-1:0] scan_addr_i,
  output logic [WIDTH-1:0] scan_data_o
);

  // Refuse an array that the address cannot cover
  if (WORDS > (2 ** ADDR_W) || WORDS < 1) begin : g_bad_size
    $error("lid_ram: WORDS does not fit ADDR_W");
  end

  // No reset on the array: contents survive soft reset and power save
  logic [WIDTH-1:0] mem [0:WORDS-1];

  // Host write port
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Host read port, one cycle latency
  always_ff @(posedge clk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end

  // Panel refresh port, independent of host traffic
  always_ff @(posedge clk_i) begin
    scan_data_o <= mem[scan_addr_i];
  end

endmodule : lid_ram

// ==== logic/lid_decoder.sv ====
// Behaviour
// - Data write stores byte, column advances
// - Data read drives addressed RAM byte
// - Normal mode: data read advances column
// - Command A0/A1 sets segment order
// - Command A4/A5 forces static drive
// - Command A8 selects one-sixteenth duty
// - Modify mode: writes advance, reads hold
// - Modify mode persists, entry column saved
// - End command leaves mode, restores column
// - Soft reset: start line 0, page 3
// - Power-on init only via reset pin
// - Display off plus static enters power save
// - Power save stops drive and clock
// - Display on or static off exits
// - Power save output cuts divider current
// - Column saturates at 50H, page fixed
// - Command AE/AF switches whole display
`timescale 1ns/10ps
module lid_decoder import lid_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_data_select_i,
  input wire logic rd_b_i,
  input wire logic wr_b_i,
  input wire logic [DATA_W-1:0] bus_in_i,
  input wire logic [COL_W-1:0] scan_seg_i,
  input wire logic [PAGE_W-1:0] scan_page_i,
  output logic [DATA_W-1:0] bus_out_o,
  output logic bus_oe_b_o,
  output logic seg_reverse_o,
  output logic static_drive_o,
  output logic duty_32_o,
  output logic display_on_o,
  output logic [LINE_W-1:0] start_line_o,
  output logic [PAGE_W-1:0] page_o,
  output logic [COL_W-1:0] column_o,
  output logic rmw_active_o,
  output logic power_save_o,
  output logic drive_enable_o,
  output logic osc_enable_o,
  output logic [DATA_W-1:0] scan_data_o
);

  logic rd_m, rd_s, rd_d;
  logic wr_m, wr_s, wr_d;
  logic cmd_m, cmd_s;
  logic [DATA_W-1:0] bus_m, bus_s;
  logic [COL_W-1:0] saved_col;
  logic rd_active, rd_is_data, rd_load;
  logic [DATA_W-1:0] ram_rd, ram_scan;
  logic [COL_W-1:0] scan_col;
  logic wr_fall, rd_fall, rd_rise;
  logic data_wr, cmd_wr, data_rd_end, col_room;
  logic [DATA_W-1:0] status_byte;

  // Pins cross into the clock domain through two flops; a third stage finds edges
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      {rd_m, rd_s, rd_d} <= 3'h7;
      {wr_m, wr_s, wr_d} <= 3'h7;
      {cmd_m, cmd_s} <= 2'h0;
      bus_m <= 8'h00;
      bus_s <= 8'h00;
    end else begin
      {rd_m, rd_s, rd_d} <= {rd_b_i, rd_m, rd_s};
      {wr_m, wr_s, wr_d} <= {wr_b_i, wr_m, wr_s};
      {cmd_m, cmd_s} <= {cmd_data_select_i, cmd_m};
      bus_m <= bus_in_i;
      bus_s <= bus_m;
    end
  end

  // A strobe counts only while the other one stays high; no strobe means no action
  assign wr_fall = wr_d & ~wr_s & rd_s;
  assign rd_fall = rd_d & ~rd_s & wr_s;
  assign rd_rise = ~rd_d & rd_s;
  assign data_wr = wr_fall & cmd_s;
  assign cmd_wr = wr_fall & ~cmd_s;
  assign data_rd_end = rd_rise & rd_active & rd_is_data;
  assign col_room = column_o < COL_LIMIT;

  // Column, page and start line; the page never follows the column
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      column_o <= COL_RST;
      page_o <= PAGE_RST;
      start_line_o <= LINE_RST;
      saved_col <= COL_RST;
    end else if (data_wr || (data_rd_end && !rmw_active_o)) begin
      if (col_room) begin
        column_o <= column_o + 7'h01;
      end
    end else if (cmd_wr) begin
      if (lid_cmd_match(bus_s, CMD_COL, MASK_COL)) begin
        column_o <= bus_s[COL_W-1:0];
      end else if (lid_cmd_match(bus_s, CMD_PAGE, MASK_PAGE)) begin
        page_o <= bus_s[PAGE_W-1:0];
      end else if (lid_cmd_match(bus_s, CMD_LINE, MASK_LINE)) begin
        start_line_o <= bus_s[LINE_W-1:0];
      end else if (lid_cmd_match(bus_s, CMD_RESET, MASK_FULL)) begin
        start_line_o <= LINE_RST;
        page_o <= PAGE_SOFT;
      end else if (lid_cmd_match(bus_s, CMD_RMW, MASK_FULL) && !rmw_active_o) begin
        saved_col <= column_o;
      end else if (lid_cmd_match(bus_s, CMD_END, MASK_FULL) && rmw_active_o) begin
        column_o <= saved_col;
      end
    end
  end

  // Mode bits; only the hardware reset pin gives them their power-on values
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      seg_reverse_o <= ADC_RST;
      static_drive_o <= STATIC_RST;
      duty_32_o <= DUTY_RST;
      display_on_o <= DISP_ON_RST;
      rmw_active_o <= 1'b0;
    end else if (cmd_wr) begin
      if (lid_cmd_match(bus_s, CMD_ADC, MASK_BIT0)) begin
        seg_reverse_o <= bus_s[0];
      end else if (lid_cmd_match(bus_s, CMD_STATIC, MASK_BIT0)) begin
        static_drive_o <= bus_s[0];
      end else if (lid_cmd_match(bus_s, CMD_DUTY, MASK_BIT0)) begin
        duty_32_o <= bus_s[0];
      end else if (lid_cmd_match(bus_s, CMD_DISP, MASK_BIT0)) begin
        display_on_o <= bus_s[0];
      end else if (lid_cmd_match(bus_s, CMD_RMW, MASK_FULL)) begin
        rmw_active_o <= 1'b1;
      end else if (lid_cmd_match(bus_s, CMD_END, MASK_FULL)) begin
        rmw_active_o <= 1'b0;
      end
    end
  end

  // Status byte: busy never set, since every command completes in one cycle
  assign status_byte = {1'b0, ~seg_reverse_o, ~display_on_o, 1'b0, 4'h0};

  // Read cycle: drive from strobe fall to strobe rise, data one cycle after the fall
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rd_active <= 1'b0;
      rd_is_data <= 1'b0;
      rd_load <= 1'b0;
      bus_out_o <= 8'h00;
      bus_oe_b_o <= 1'b1;
    end else if (rd_fall) begin
      rd_active <= 1'b1;
      rd_is_data <= cmd_s;
      rd_load <= 1'b1;
      bus_oe_b_o <= 1'b0;
    end else if (rd_rise) begin
      rd_active <= 1'b0;
      rd_load <= 1'b0;
      bus_oe_b_o <= 1'b1;
    end else if (rd_load) begin
      bus_out_o <= rd_is_data ? ram_rd : status_byte;
      rd_load <= 1'b0;
    end
  end

  // Power save follows the pair of mode bits, whichever changed last
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      power_save_o <= 1'b0;
      drive_enable_o <= 1'b1;
      osc_enable_o <= 1'b1;
    end else begin
      power_save_o <= ~display_on_o & static_drive_o;
      drive_enable_o <= ~(~display_on_o & static_drive_o);
      osc_enable_o <= ~(~display_on_o & static_drive_o);
    end
  end

  // Segment order reverses which column feeds a segment
  assign scan_col = seg_reverse_o ? SEG_LAST - scan_seg_i : scan_seg_i;

  // Panel data: blank in power save, all dots in static drive, else RAM
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      scan_data_o <= DOTS_OFF;
    end else if (power_save_o) begin
      scan_data_o <= DOTS_OFF;
    end else if (static_drive_o) begin
      scan_data_o <= DOTS_ALL_ON;
    end else begin
      scan_data_o <= ram_scan;
    end
  end

  // Writes past the last column are dropped rather than wrapped
  lid_ram #(
    .WIDTH(DATA_W),
    .ADDR_W(RAM_ADDR_W),
    .WORDS(512)
  ) u_ram (
    .clk_i(clk_i),
    .wr_en_i(data_wr && col_room),
    .wr_addr_i({page_o, column_o}),
    .wr_data_i(bus_s),
    .rd_addr_i({page_o, column_o}),
    .rd_data_o(ram_rd),
    .scan_addr_i({scan_page_i, scan_col}),
    .scan_data_o(ram_scan)
  );

  a_wr_col_incr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    data_wr && col_room |=> column_o == $past(column_o) + 7'h01) else $error("write did not advance column");
  a_rd_drive_window: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_fall |=> !bus_oe_b_o ##1 (bus_out_o == $past(ram_rd) || !rd_is_data)) else $error("read not driven");
  a_rd_col_incr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    data_rd_end && !rmw_active_o && col_room |=> column_o == $past(column_o) + 7'h01)
    else $error("read did not advance column");
  a_seg_order_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cmd_wr && bus_s[7:1] == 7'h50 |=> seg_reverse_o == $past(bus_s[0])) else $error("segment order wrong");
  a_static_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cmd_wr && bus_s[7:1] == 7'h52 |=> static_drive_o == $past(bus_s[0])) else $error("static drive wrong");
  a_duty_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cmd_wr && bus_s[7:1] == 7'h54 |=> duty_32_o == $past(bus_s[0])) else $error("duty wrong");
  a_rmw_rd_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    data_rd_end && rmw_active_o |=> $stable(column_o)) else $error("modify read moved column");
  a_rmw_persist: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rmw_active_o && !(cmd_wr && bus_s == 8'hEE) |=> rmw_active_o) else $error("modify mode dropped");
  a_end_restore: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cmd_wr && bus_s == 8'hEE && rmw_active_o |=> column_o == $past(saved_col) && !rmw_active_o)
    else $error("end did not restore column");
  a_soft_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cmd_wr && bus_s == 8'hE2 |=> page_o == 2'h3 && start_line_o == 5'h00) else $error("soft reset wrong");
  a_psave_enter: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !display_on_o && static_drive_o |=> power_save_o && !drive_enable_o && !osc_enable_o)
    else $error("power save not entered");
  a_psave_exit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    display_on_o || !static_drive_o |=> !power_save_o && drive_enable_o) else $error("power save not left");
  a_col_ceiling: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    data_wr && !col_room |=> column_o == 7'h50 && $stable(page_o)) else $error("column passed ceiling");
  a_idle_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !wr_fall && !rd_rise |=> $stable(column_o) && $stable(rmw_active_o)) else $error("idle cycle changed state");

endmodule : lid_decoder

// ==== verif/lid_host.sv ====
`timescale 1ns/10ps
module lid_host import lid_pkg::*; (
  input wire logic clk_i,
  input wire logic [DATA_W-1:0] dev_data_i,
  input wire logic dev_oe_b_i,
  output logic cds_o,
  output logic rd_b_o,
  output logic wr_b_o,
  output logic [DATA_W-1:0] bus_o,
  output logic rd_valid_o,
  output logic [DATA_W-1:0] rd_data_o
);
  logic [DATA_W-1:0] drv = 8'h00;
  // Released bus shows the inverse of the last byte so stale data never passes
  assign bus_o = dev_oe_b_i ? drv : dev_data_i;
  initial begin
    cds_o = 1'b0;
    rd_b_o = 1'b1;
    wr_b_o = 1'b1;
    rd_valid_o = 1'b0;
    rd_data_o = 8'h00;
  end
  // Byte held three clocks either side of a five clock strobe; no busy wait needed
  task automatic put(input logic cds, input logic [DATA_W-1:0] b);
    @(posedge clk_i);
    cds_o <= cds;
    drv <= b;
    repeat (3) @(posedge clk_i);
    wr_b_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    wr_b_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    drv <= ~b;
    repeat (2) @(posedge clk_i);
  endtask : put
  // Read of data or status; keep low marks a dummy read whose byte is thrown away
  task automatic get(input logic cds, input logic keep);
    @(posedge clk_i);
    cds_o <= cds;
    repeat (3) @(posedge clk_i);
    rd_b_o <= 1'b0;
    repeat (7) @(posedge clk_i);
    rd_data_o <= bus_o;
    rd_valid_o <= keep;
    rd_b_o <= 1'b1;
    @(posedge clk_i);
    rd_valid_o <= 1'b0;
    repeat (7) @(posedge clk_i);
  endtask : get
endmodule : lid_host

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench import lid_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [COL_W-1:0] seg = 7'h00;
  logic [PAGE_W-1:0] spage = 2'h0;
  logic cds, rd_b, wr_b, oe_b, seg_rev, stat, duty, don, rmw, ps, drv_en, osc_en, rd_valid;
  logic [DATA_W-1:0] bus, bus_out, scan, rd_data;
  logic [LINE_W-1:0] line;
  logic [PAGE_W-1:0] page;
  logic [COL_W-1:0] col;
  int bad_count = 0;
  int total_checks = 0;
  logic [DATA_W-1:0] notes[$];
  logic [DATA_W-1:0] wd[3];
  logic [31:0] rng = 32'hE0CF;
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  lid_host lid_host_i (.clk_i(clk_i), .dev_data_i(bus_out), .dev_oe_b_i(oe_b), .cds_o(cds), .rd_b_o(rd_b),
    .wr_b_o(wr_b), .bus_o(bus), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  lid_decoder lid_decoder_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_data_select_i(cds), .rd_b_i(rd_b),
    .wr_b_i(wr_b), .bus_in_i(bus), .scan_seg_i(seg), .scan_page_i(spage), .bus_out_o(bus_out),
    .bus_oe_b_o(oe_b), .seg_reverse_o(seg_rev), .static_drive_o(stat), .duty_32_o(duty),
    .display_on_o(don), .start_line_o(line), .page_o(page), .column_o(col), .rmw_active_o(rmw),
    .power_save_o(ps), .drive_enable_o(drv_en), .osc_enable_o(osc_en), .scan_data_o(scan));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // Panel refresh sample, two edges of latency plus margin
  task automatic look(input logic [PAGE_W-1:0] p, input logic [COL_W-1:0] s, input logic [DATA_W-1:0] exp);
    @(posedge clk_i);
    spage <= p;
    seg <= s;
    repeat (4) @(posedge clk_i);
    check(scan, exp);
  endtask : look
  // Oldest note is matched against each kept read
  always @(posedge clk_i) begin
    if (rd_valid === 1'b1) begin
      check(rd_data, notes.pop_front());
    end
  end
  // Whole run is about six hundred clocks; this limit stops it at 20000
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({7'h00, oe_b}, 8'h01);
    check({1'b0, col}, 8'h00);
    check({7'h00, ps | ~drv_en | ~osc_en}, 8'h00);
    lid_host_i.put(1'b0, 8'hB9);
    lid_host_i.put(1'b0, 8'h10);
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      wd[i] = rng[7:0];
      lid_host_i.put(1'b1, wd[i]);
      check({1'b0, col}, 8'(8'h11 + i));
    end
    for (int i = 0; i < 3; i++) look(2'h1, 7'h10 + i, wd[i]);
    lid_host_i.put(1'b0, CMD_ADC | 8'h01);
    look(2'h1, SEG_LAST - 7'h10, wd[0]);
    lid_host_i.put(1'b0, CMD_ADC);
    // Modify mode: reads hold the column, writes move it, End restores it
    lid_host_i.put(1'b0, 8'h10);
    lid_host_i.put(1'b0, CMD_RMW);
    lid_host_i.get(1'b1, 1'b0);
    notes.push_back(wd[0]);
    notes.push_back(wd[0]);
    lid_host_i.get(1'b1, 1'b1);
    lid_host_i.get(1'b1, 1'b1);
    check({1'b0, col}, 8'h10);
    rng = xs(rng);
    wd[0] = rng[7:0];
    lid_host_i.put(1'b1, wd[0]);
    check({1'b0, col}, 8'h11);
    lid_host_i.put(1'b0, 8'hC3);
    check({7'h00, rmw}, 8'h01);
    lid_host_i.put(1'b0, CMD_END);
    check({6'h00, rmw, col == 7'h10}, 8'h01);
    notes.push_back(wd[0]);
    lid_host_i.get(1'b1, 1'b1);
    check({1'b0, col}, 8'h11);
    check({3'h0, line}, 8'h03);
    lid_host_i.put(1'b0, CMD_RESET);
    check({1'b0, line, page}, {1'b0, LINE_RST, PAGE_SOFT});
    check({1'b0, col}, 8'h11);
    lid_host_i.put(1'b0, 8'h4F);
    lid_host_i.put(1'b1, 8'h5A);
    lid_host_i.put(1'b1, 8'hA5);
    check({page, col == COL_LIMIT, 5'h00}, {PAGE_SOFT, 6'h20});
    look(2'h3, SEG_LAST, 8'h5A);
    lid_host_i.put(1'b0, 8'hE5);
    check({line, page, col == COL_LIMIT}, {LINE_RST, PAGE_SOFT, 1'b1});
    // Every mode command in both settings
    for (int d = 1; d >= 0; d--) begin
      lid_host_i.put(1'b0, CMD_ADC | d[7:0]);
      check({7'h00, seg_rev}, d[7:0]);
      lid_host_i.put(1'b0, CMD_DISP | d[7:0]);
      check({7'h00, don}, d[7:0]);
      lid_host_i.put(1'b0, CMD_STATIC | d[7:0]);
      check({7'h00, stat}, d[7:0]);
      if (d == 1) look(2'h0, 7'h05, DOTS_ALL_ON);
      lid_host_i.put(1'b0, CMD_DUTY | d[7:0]);
      check({7'h00, duty}, d[7:0]);
    end
    // Power save entered from either order, left by either command
    lid_host_i.put(1'b0, CMD_STATIC | 8'h01);
    check({5'h00, ps, drv_en, osc_en}, 8'h04);
    look(2'h3, SEG_LAST, DOTS_OFF);
    lid_host_i.put(1'b0, CMD_DISP | 8'h01);
    check({5'h00, ps, drv_en, osc_en}, 8'h03);
    lid_host_i.put(1'b0, CMD_DISP);
    check({5'h00, ps, stat, seg_rev}, 8'h06);
    lid_host_i.put(1'b0, CMD_STATIC);
    check({5'h00, ps, drv_en, osc_en}, 8'h03);
    look(2'h3, SEG_LAST, 8'h5A);
    // Status read: ready, forward order, display off
    notes.push_back(8'h60);
    lid_host_i.get(1'b0, 1'b1);
    // Reset pin in mid-run clears every mode but leaves display RAM alone
    lid_host_i.put(1'b0, CMD_ADC | 8'h01);
    lid_host_i.put(1'b0, CMD_DUTY | 8'h01);
    lid_host_i.put(1'b0, CMD_STATIC | 8'h01);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({seg_rev, stat, duty, don, rmw, ps, drv_en, osc_en}, 8'h03);
    check({1'b0, line, page}, 8'h00);
    check({1'b0, col}, 8'h00);
    look(2'h3, SEG_LAST, 8'h5A);
    check(8'(notes.size()), 8'h00);
    report_and_stop();
  end
endmodule : testbench
